// ---- hdl/msc_module_stop.sv ----
// peripheral module stop control: four 8-bit stop registers on apb and
// one registered stop request per peripheral
// assumes apb master on pclk; peripherals keep their state while stopped
//
// Contract
// RULE_01: stop bit one stops module, zero runs
// RULE_02: high bits 6,5,4 stop dtc, frt, timers
// RULE_03: high bits 3,1,0 stop pwm, adc, timers
// RULE_04: software rewrites reserved bits with reset values
// RULE_05: low bits 7,6 stop serial interfaces
// RULE_06: low bits 4,3 stop two-wire channels
// RULE_07: aux pwm bits 1,0 stop pwm timers
// RULE_08: wide pwm runs only when both bits clear
// RULE_09: narrow pwm runs only when both clear
// RULE_10: aux cycle bits 1,0 stop cycle timers
// RULE_11: stopped modules keep their register state
// RULE_12: one stop output each, registers read/write
`timescale 1ns/100ps

module msc_module_stop
    import msc_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [MSC_ADDR_W-1:0] paddr,
    input  wire logic [MSC_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [MSC_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    output msc_stop_type               stop_req
);

    msc_regs_type              regs_r;
    msc_regs_type              regs_nxt;
    msc_stop_type              stop_r;
    msc_stop_type              stop_nxt;
    logic                      pready_r;
    logic                      pslverr_r;
    logic [MSC_DATA_W-1:0]     prdata_r;

    // address decode
    wire logic sel_high   = (paddr == MSC_OFS_HIGH);
    wire logic sel_low    = (paddr == MSC_OFS_LOW);
    wire logic sel_apwm   = (paddr == MSC_OFS_AUX_PWM);
    wire logic sel_acyc   = (paddr == MSC_OFS_AUX_CYCLE);
    wire logic sel_any    = sel_high | sel_low | sel_apwm | sel_acyc;

    // setup cycle arms a one-cycle access; answer comes with no wait state
    wire logic setup_ph   = psel & ~penable & ~pready_r;
    wire logic access_end = psel & penable & pready_r;
    // only lane 0 carries register data, so only pstrb[0] gates a write
    wire logic wr_en      = access_end & pwrite & sel_any & pstrb[0];
    wire logic [MSC_REG_W-1:0] wbyte = pwdata[MSC_REG_W-1:0];

    // read mux, unmapped reads return zero
    wire logic [MSC_REG_W-1:0] rd_byte =
        sel_high ? regs_r.high     :
        sel_low  ? regs_r.low      :
        sel_apwm ? regs_r.aux_pwm  :
        sel_acyc ? regs_r.aux_cycle : '0;

    // all eight bits of each register are plain read/write, reserved ones too
    always_comb begin
        regs_nxt = regs_r;
        if (wr_en && sel_high) begin
            regs_nxt.high = wbyte;            // see RULE_12
        end
        if (wr_en && sel_low) begin
            regs_nxt.low = wbyte;
        end
        if (wr_en && sel_apwm) begin
            regs_nxt.aux_pwm = wbyte;
        end
        if (wr_en && sel_acyc) begin
            regs_nxt.aux_cycle = wbyte;
        end
    end

    // decode of a register image into stop requests; used for the live value and for the
    // reset image, so the two can never disagree
    function automatic msc_stop_type stop_of(input msc_regs_type r);
        msc_stop_type s;
        s.data_transfer_controller = r.high[MSC_HI_DTC_BIT];   // see RULE_02
        s.free_running_timer       = r.high[MSC_HI_FRT_BIT];   // see RULE_02
        s.byte_timer_a             = r.high[MSC_HI_BTA_BIT];   // see RULE_02
        s.adc                      = r.high[MSC_HI_ADC_BIT];   // see RULE_03
        s.byte_timer_b             = r.high[MSC_HI_BTB_BIT];   // see RULE_03
        s.wide_pulse_timer         = msc_pwm_stop(r.high[MSC_HI_PWM_BIT],
                                                  r.aux_pwm[MSC_AP_WIDE_BIT]);   // see RULE_03 RULE_07 RULE_08
        s.narrow_pwm_timer         = msc_pwm_stop(r.high[MSC_HI_PWM_BIT],
                                                  r.aux_pwm[MSC_AP_NARROW_BIT]); // see RULE_07 RULE_09
        s.serial_iface_0           = r.low[MSC_LO_SER0_BIT];         // see RULE_05
        s.serial_iface_1           = r.low[MSC_LO_SER1_BIT];         // see RULE_05
        s.two_wire_channel_0       = r.low[MSC_LO_TWC0_BIT];         // see RULE_06
        s.two_wire_channel_1       = r.low[MSC_LO_TWC1_BIT];         // see RULE_06
        s.cycle_meas_timer_0       = r.aux_cycle[MSC_AC_CMT0_BIT];   // see RULE_10
        s.cycle_meas_timer_1       = r.aux_cycle[MSC_AC_CMT1_BIT];   // see RULE_10
        return s;
    endfunction

    // reset images of the register file and of the stop outputs
    localparam msc_regs_type REGS_RST = '{high: MSC_RST_HIGH, low: MSC_RST_LOW,
                                          aux_pwm: MSC_RST_AUX_PWM, aux_cycle: MSC_RST_AUX_CYCLE};
    localparam msc_stop_type STOP_RST = stop_of(REGS_RST);

    // stop requests follow the next register value so they change at the same edge as the register
    assign stop_nxt = stop_of(regs_nxt);

    // register file and stop outputs; a 1 stops, a 0 lets the module run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_r <= REGS_RST;     // see RULE_02 RULE_06 RULE_07
            stop_r <= STOP_RST;     // see RULE_05 RULE_10
        end else begin
            regs_r <= regs_nxt;
            stop_r <= stop_nxt;                                                  // see RULE_01
        end
    end

    // apb answer: ready, data and error stand for exactly the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~sel_any;
            prdata_r  <= (setup_ph && !pwrite) ? {MSC_RD_PAD, rd_byte} : '0;
        end
    end

    // stop is a level request only: it gates the module's clock and never resets it,
    // so a stopped peripheral resumes with its registers intact
    assign stop_req = stop_r;     // see RULE_11
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign prdata   = prdata_r;

endmodule // msc_module_stop

// ---- hdl/msc_pkg.sv ----
// constants, field positions and types of the peripheral module stop control block
// assumes a 32-bit apb slave port with word aligned registers
package msc_pkg;

    // register byte offsets
    localparam logic [7:0] MSC_OFS_HIGH      = 8'h00;
    localparam logic [7:0] MSC_OFS_LOW       = 8'h04;
    localparam logic [7:0] MSC_OFS_AUX_PWM   = 8'h08;
    localparam logic [7:0] MSC_OFS_AUX_CYCLE = 8'h0c;

    // reset values of the four stop registers
    localparam logic [7:0] MSC_RST_HIGH      = 8'h3f;
    localparam logic [7:0] MSC_RST_LOW       = 8'hff;
    localparam logic [7:0] MSC_RST_AUX_PWM   = 8'h00;
    localparam logic [7:0] MSC_RST_AUX_CYCLE = 8'hff;

    // field positions in module_stop_high
    localparam int MSC_HI_DTC_BIT    = 6;
    localparam int MSC_HI_FRT_BIT    = 5;
    localparam int MSC_HI_BTA_BIT    = 4;
    localparam int MSC_HI_PWM_BIT    = 3;
    localparam int MSC_HI_ADC_BIT    = 1;
    localparam int MSC_HI_BTB_BIT    = 0;
    // field positions in module_stop_low
    localparam int MSC_LO_SER0_BIT   = 7;
    localparam int MSC_LO_SER1_BIT   = 6;
    localparam int MSC_LO_TWC0_BIT   = 4;
    localparam int MSC_LO_TWC1_BIT   = 3;
    // field positions in the auxiliary registers
    localparam int MSC_AP_WIDE_BIT   = 1;
    localparam int MSC_AP_NARROW_BIT = 0;
    localparam int MSC_AC_CMT1_BIT   = 1;
    localparam int MSC_AC_CMT0_BIT   = 0;

    // apb geometry
    localparam int          MSC_ADDR_W   = 8;
    localparam int          MSC_DATA_W   = 32;
    localparam int          MSC_REG_W    = 8;
    localparam logic [23:0] MSC_RD_PAD   = 24'h000000;

    // one stop request per controlled peripheral, high = stopped
    typedef struct packed {
        logic data_transfer_controller;
        logic free_running_timer;
        logic byte_timer_a;          // byte_timer_a0 and byte_timer_a1
        logic narrow_pwm_timer;
        logic wide_pulse_timer;
        logic adc;
        logic byte_timer_b;          // byte_timer_bx and byte_timer_by
        logic serial_iface_0;
        logic serial_iface_1;
        logic two_wire_channel_0;
        logic two_wire_channel_1;
        logic cycle_meas_timer_0;
        logic cycle_meas_timer_1;
    } msc_stop_type;

    // the register file as one carrier
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic [7:0] aux_pwm;
        logic [7:0] aux_cycle;
    } msc_regs_type;

    // a pwm timer runs only when the shared and its own bit are both clear
    function automatic logic msc_pwm_stop(input logic shared_pwm_stop_bit, input logic own_bit);
        return shared_pwm_stop_bit | own_bit;
    endfunction

endpackage

// ---- testbench/msc_stop_sva.sv ----
// checker of the stop control apb port and its stop outputs
// sees only the top ports; bound from tb_top
`timescale 1ns/100ps
module msc_stop_sva import msc_pkg::*; (
    input wire logic         pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata, prdata,
    input wire logic [3:0]   pstrb,
    input wire msc_stop_type stop_req);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a committed write; stop outputs follow it one edge later
    wire wr = psel && penable && pwrite && pready && pstrb[0];
    hi_bits_a: assert property (wr && paddr == 8'h00 |=> {stop_req.data_transfer_controller,
        stop_req.free_running_timer, stop_req.byte_timer_a, stop_req.adc, stop_req.byte_timer_b}
        == $past({pwdata[6:4], pwdata[1:0]})) else $error("high stop bits not followed");
    pwm_share_a: assert property (wr && paddr == 8'h00 && pwdata[3] |=>
        stop_req.wide_pulse_timer && stop_req.narrow_pwm_timer) else $error("shared pwm bit ignored");
    pwm_own_a: assert property (wr && paddr == 8'h08 |=>
        stop_req.wide_pulse_timer >= $past(pwdata[1]) && stop_req.narrow_pwm_timer >= $past(pwdata[0]))
        else $error("own pwm bit ignored");
    low_bits_a: assert property (wr && paddr == 8'h04 |=> {stop_req.serial_iface_0,
        stop_req.serial_iface_1, stop_req.two_wire_channel_0, stop_req.two_wire_channel_1}
        == $past({pwdata[7:6], pwdata[4:3]})) else $error("low stop bits not followed");
    cyc_bits_a: assert property (wr && paddr == 8'h0c |=>
        {stop_req.cycle_meas_timer_0, stop_req.cycle_meas_timer_1} == $past({pwdata[0], pwdata[1]}))
        else $error("cycle timer bits not followed");
    stop_hold_a: assert property (!wr |=> $stable(stop_req)) else $error("stop changed without write");
    ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    err_map_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h0c))
        else $error("pslverr wrong for address");
    cover property (wr && paddr == 8'h08 && pwdata[1:0] == 2'b00);
    cover property (pready && pslverr);
    cover property (pready && !pwrite && prdata[7:0] != 8'h00);
endmodule // msc_stop_sva

// ---- testbench/tb_top.sv ----
// self-checking bench of the stop control block against a byte model
// assumes msc_pkg, the design and the checker compiled first
`timescale 1ns/100ps
module tb_top import msc_pkg::*; ;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd;
    logic [3:0]   pstrb = 4'h0;
    msc_stop_type stop_req;
    int           n_mismatch = 0, checks_done = 0;
    int           mdl[4] = '{8'h3f, 8'hff, 8'h00, 8'hff}; // reset image of the four bytes
    int           msk[4] = '{8'h7b, 8'hd8, 8'h03, 8'h03}; // bits that are not reserved
    always #25 pclk = ~pclk;
    msc_module_stop msc_module_stop_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_req(stop_req));
    // one compare for bus values
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // stop image from the model: a pwm timer needs both its bits clear to run
    task automatic chk_stop();
        logic [12:0] ex;
        ex = {mdl[0][6:4], mdl[0][3] | mdl[2][0], mdl[0][3] | mdl[2][1], mdl[0][1:0],
              mdl[1][7:6], mdl[1][4:3], mdl[3][0], mdl[3][1]};
        @(negedge pclk);
        chk("stop_req", 32'(ex), 32'(stop_req));
    endtask
    // one apb transfer; answer taken at the rising edge where pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ok;
        ok = a[1:0] == 2'b00 && a < 8'h10;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (w && s[0] && ok) mdl[a[3:2]] = d[7:0];
        if (!w) chk("prdata", ok ? mdl[a[3:2]] : 0, rd);
        chk("pslverr", 32'(!ok), 32'(er));
        chk_stop();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog, well beyond the roughly 670 cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end
    initial begin
        int a;
        logic [31:0] d;
        void'($urandom(65));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset image of every register and one unmapped word
        for (int i = 0; i < 5; i++) apb(0, 8'(4 * i), 0, 4'h0);
        $display("test reset done");
        // every shared and own pwm combination, reserved bits kept as after reset
        for (int k = 0; k < 8; k++) begin
            apb(1, 8'h00, 32'h37 | (k & 4) << 1, 4'h1);
            apb(1, 8'h08, k & 3, 4'h1);
        end
        $display("test pwm done");
        // random traffic with dropped strobes and the unmapped word
        for (int n = 0; n < 200; n++) begin
            a = $urandom_range(4);
            d = $urandom;
            if (a < 4) d = d & msk[a] | mdl[a] & ~msk[a];
            apb($urandom_range(1), 8'(4 * a), d, 4'($urandom_range(15)));
        end
        $display("test random done");
        close_out();
    end
endmodule // tb_top
bind msc_module_stop msc_stop_sva msc_stop_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pstrb(pstrb), .stop_req(stop_req));
